// [rtl/lpmc_consts.svh]
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH

// clock rate and low power clock ceilings, in MHz
`define LPMC_CLK_MHZ       125
`define LPMC_VLP_CORE_MHZ  2
`define LPMC_VLP_BUS_MHZ   1
// a ceiling on frequency is a least period: round up
`define LPMC_CORE_DIV ((`LPMC_CLK_MHZ+`LPMC_VLP_CORE_MHZ-1)/`LPMC_VLP_CORE_MHZ)
`define LPMC_BUS_DIV  ((`LPMC_CLK_MHZ+`LPMC_VLP_BUS_MHZ-1)/`LPMC_VLP_BUS_MHZ)
`define LPMC_DIV_W    7

// stop mode selection codes
`define LPMC_SEL_STOP  3'h0
`define LPMC_SEL_VERY_LOW_POWER_STOP  3'h1
`define LPMC_SEL_LLS   3'h2
`define LPMC_SEL_DLS3  3'h3
`define LPMC_SEL_DLS2  3'h4
`define LPMC_SEL_DLS1  3'h5

// ram bank power bits
`define LPMC_RAM_B1    3'h1
`define LPMC_RAM_B2    3'h2
`define LPMC_RAM_ALL   3'h7
`define LPMC_RAM_NONE  3'h0

`endif

// [rtl/lpmc_pkg.sv]
package lpmc_pkg;

  typedef enum logic [3:0] {
    LPMC_RUN  = 4'b0000,
    LPMC_WAIT = 4'b0001,
    LPMC_STOP = 4'b0010,
    LPMC_VERY_LOW_POWER_RUN = 4'b0011,
    LPMC_VERY_LOW_POWER_WAIT = 4'b0100,
    LPMC_VERY_LOW_POWER_STOP = 4'b0101,
    LPMC_LLS  = 4'b0110,
    LPMC_DLS3 = 4'b0111,
    LPMC_DLS2 = 4'b1000,
    LPMC_DLS1 = 4'b1001,
    LPMC_WRST = 4'b1010
  } lpmc_mode_e;

  typedef struct packed {
    logic       cpu_clk_on;
    logic       sys_clk_on;
    logic       clk_limit;
    logic       reg_lp;
    logic       lvd_en;
    logic       adc_pin_irq_en;
    logic       lp_periph_en;
    logic       wkup_unit_en;
    logic [2:0] ram_pwr;
    logic       regfile_pwr;
    logic       io_hold;
  } lpmc_cfg_s;

endpackage : lpmc_pkg

// [rtl/lpmc_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module lpmc_sync
  import lpmc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // async level in, filtered level out
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic [2:0] sh;
    logic       val;
  } lpmc_sync_s;

  lpmc_sync_s st_ff;
  lpmc_sync_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.sh = {st_ff.sh[1:0], async_in};
    // stage 0 is read only by stage 1
    if (st_ff.sh[1] == st_ff.sh[2]) begin
      nxt_st.val = st_ff.sh[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.val;

endmodule : lpmc_sync

`default_nettype wire

// [rtl/lpmc_tick.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.svh"

module lpmc_tick
  import lpmc_pkg::*;
#(
  parameter logic [`LPMC_DIV_W-1:0] DIV = `LPMC_DIV_W'(`LPMC_BUS_DIV)
)(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // limit on: one tick per DIV cycles, else every cycle
  input  wire logic limit,
  output logic      tick
);

  typedef struct packed {
    logic [`LPMC_DIV_W-1:0] cnt;
    logic                   tick;
  } lpmc_tick_s;

  lpmc_tick_s st_ff;
  lpmc_tick_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!limit) begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end else if (st_ff.cnt == DIV - `LPMC_DIV_W'(1)) begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt  = st_ff.cnt + `LPMC_DIV_W'(1);
      nxt_st.tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : lpmc_tick

`default_nettype wire

// [rtl/lpmc_top.sv]
// What this block does
// - sleep request enters wait or stop mode; this block picks which one
// - input/output pin state is held frozen in every low power mode except very low power run
// - normal wait stops core clock, peripherals run, interrupt returns
// - normal stop: static, registers kept, voltage detector on
// - very low power run: regulator low power, detector off, 2/1 MHz
// - very low power wait keeps run limits, core clock off
// - very low power stop: static, detector off, analog and pins alive
// - low leakage stop keeps logic, all ram; exits on wakeup unit only
// - deep stop three keeps all ram, register file; exit by reset
// - deep stop two powers off part of ram; exit by reset
// - deep stop one powers off all ram; register file kept
// - system clocked peripherals see reduced limits in low power run
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_consts.svh"

module lpmc_top
  import lpmc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // core side
  input  wire logic       sleep_req,
  input  wire logic       sleep_deep,
  input  wire logic       irq_pending,
  // software mode selection
  input  wire logic       vlp_run_req,
  input  wire logic [2:0] stop_mode_sel,
  input  wire logic       ram2_keep,
  // wakeup unit, asynchronous
  input  wire logic       wkup_irq_async,
  // clock control
  output logic            cpu_clk_on,
  output logic            sys_clk_on,
  output logic            clk_limit,
  output logic            core_tick,
  output logic            bus_tick,
  // power control
  output logic            reg_lp,
  output logic            lvd_en,
  output logic [2:0]      ram_pwr,
  output logic            regfile_pwr,
  // peripheral keep alive
  output logic            adc_pin_irq_en,
  output logic            lp_periph_en,
  output logic            wkup_unit_en,
  // pins and status
  output logic            io_hold,
  output logic            wakeup_reset,
  output logic [3:0]      mode_status
);

  typedef struct packed {
    lpmc_mode_e mode;
    logic       prev_vlp;
    logic       wrst;
    lpmc_cfg_s  cfg;
  } lpmc_top_s;

  lpmc_top_s st_ff;
  lpmc_top_s nxt_st;
  logic      wkup_irq;

  // stop target chosen from software selection
  function automatic lpmc_mode_e stop_target(
    input logic [2:0] sel,
    input logic       from_vlp
  );
    lpmc_mode_e m;
    case (sel)
      `LPMC_SEL_STOP: begin
        // normal stop needs full regulator; low power run falls to very_low_power_stop
        m = from_vlp ? LPMC_VERY_LOW_POWER_STOP : LPMC_STOP;
      end
      `LPMC_SEL_VERY_LOW_POWER_STOP: m = LPMC_VERY_LOW_POWER_STOP;
      `LPMC_SEL_LLS:  m = LPMC_LLS;
      `LPMC_SEL_DLS3: m = LPMC_DLS3;
      `LPMC_SEL_DLS2: m = LPMC_DLS2;
      `LPMC_SEL_DLS1: m = LPMC_DLS1;
      default:        m = from_vlp ? LPMC_VERY_LOW_POWER_STOP : LPMC_STOP;
    endcase
    return m;
  endfunction : stop_target

  // per mode clock, power and keep alive settings
  function automatic lpmc_cfg_s mode_cfg(
    input lpmc_mode_e m,
    input logic       keep2
  );
    lpmc_cfg_s c;
    c.cpu_clk_on     = (m == LPMC_RUN) || (m == LPMC_VERY_LOW_POWER_RUN);
    c.sys_clk_on     = (m == LPMC_RUN) || (m == LPMC_WAIT)
                       || (m == LPMC_VERY_LOW_POWER_RUN) || (m == LPMC_VERY_LOW_POWER_WAIT);
    c.clk_limit      = (m == LPMC_VERY_LOW_POWER_RUN) || (m == LPMC_VERY_LOW_POWER_WAIT);
    c.lvd_en         = (m == LPMC_RUN) || (m == LPMC_WAIT)
                       || (m == LPMC_STOP);
    c.reg_lp         = !c.lvd_en && (m != LPMC_WRST);
    c.adc_pin_irq_en = (m != LPMC_LLS) && (m != LPMC_DLS3)
                       && (m != LPMC_DLS2) && (m != LPMC_DLS1);
    c.lp_periph_en   = 1'b1;
    c.wkup_unit_en   = (m == LPMC_LLS) || (m == LPMC_DLS3)
                       || (m == LPMC_DLS2) || (m == LPMC_DLS1);
    c.regfile_pwr    = 1'b1;
    case (m)
      LPMC_DLS2: begin
        c.ram_pwr = `LPMC_RAM_B1 | (keep2 ? `LPMC_RAM_B2 : `LPMC_RAM_NONE);
      end
      LPMC_DLS1: c.ram_pwr = `LPMC_RAM_NONE;
      default:   c.ram_pwr = `LPMC_RAM_ALL;
    endcase
    // pins frozen whenever core clock is off, except in the wakeup reset state
    c.io_hold        = !c.cpu_clk_on && (m != LPMC_WRST);
    return c;
  endfunction : mode_cfg

  lpmc_sync u_wkup_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (wkup_irq_async),
    .sync_out (wkup_irq)
  );

  // core clock ceiling
  lpmc_tick #(
    .DIV (`LPMC_DIV_W'(`LPMC_CORE_DIV))
  ) u_core_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .limit    (st_ff.cfg.clk_limit),
    .tick     (core_tick)
  );

  // bus, flash and system clocked peripherals ceiling
  lpmc_tick #(
    .DIV (`LPMC_DIV_W'(`LPMC_BUS_DIV))
  ) u_bus_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .limit    (st_ff.cfg.clk_limit),
    .tick     (bus_tick)
  );

  always_comb begin
    lpmc_mode_e back;
    back        = st_ff.prev_vlp ? LPMC_VERY_LOW_POWER_RUN : LPMC_RUN;
    nxt_st      = st_ff;
    nxt_st.wrst = 1'b0;
    case (st_ff.mode)
      LPMC_RUN: begin
        nxt_st.prev_vlp = 1'b0;
        if (sleep_req) begin
          // one sleep instruction, this block decides the depth
          nxt_st.mode = sleep_deep ? stop_target(stop_mode_sel, 1'b0)
                                   : LPMC_WAIT;
        end else if (vlp_run_req) begin
          nxt_st.mode = LPMC_VERY_LOW_POWER_RUN;
        end
      end
      LPMC_VERY_LOW_POWER_RUN: begin
        nxt_st.prev_vlp = 1'b1;
        if (sleep_req) begin
          nxt_st.mode = sleep_deep ? stop_target(stop_mode_sel, 1'b1)
                                   : LPMC_VERY_LOW_POWER_WAIT;
        end else if (!vlp_run_req) begin
          nxt_st.mode = LPMC_RUN;
        end
      end
      LPMC_WAIT, LPMC_STOP, LPMC_VERY_LOW_POWER_WAIT, LPMC_VERY_LOW_POWER_STOP: begin
        if (irq_pending) begin
          nxt_st.mode = back;
        end
      end
      LPMC_LLS: begin
        // ordinary interrupts cannot reach a leakage mode
        if (wkup_irq) begin
          nxt_st.mode = back;
        end
      end
      LPMC_DLS3, LPMC_DLS2, LPMC_DLS1: begin
        if (wkup_irq) begin
          nxt_st.mode = LPMC_WRST;
          nxt_st.wrst = 1'b1;
        end
      end
      LPMC_WRST: begin
        // execution restarts from reset in normal run
        nxt_st.mode     = LPMC_RUN;
        nxt_st.prev_vlp = 1'b0;
      end
      default: begin
        nxt_st.mode     = LPMC_RUN;
        nxt_st.prev_vlp = 1'b0;
      end
    endcase
    nxt_st.cfg = mode_cfg(nxt_st.mode, ram2_keep);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff.mode     <= LPMC_RUN;
      st_ff.prev_vlp <= 1'b0;
      st_ff.wrst     <= 1'b0;
      st_ff.cfg      <= mode_cfg(LPMC_RUN, 1'b0);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cpu_clk_on     = st_ff.cfg.cpu_clk_on;
  assign sys_clk_on     = st_ff.cfg.sys_clk_on;
  assign clk_limit      = st_ff.cfg.clk_limit;
  assign reg_lp         = st_ff.cfg.reg_lp;
  assign lvd_en         = st_ff.cfg.lvd_en;
  assign ram_pwr        = st_ff.cfg.ram_pwr;
  assign regfile_pwr    = st_ff.cfg.regfile_pwr;
  assign adc_pin_irq_en = st_ff.cfg.adc_pin_irq_en;
  assign lp_periph_en   = st_ff.cfg.lp_periph_en;
  assign wkup_unit_en   = st_ff.cfg.wkup_unit_en;
  assign io_hold        = st_ff.cfg.io_hold;
  assign wakeup_reset   = st_ff.wrst;
  assign mode_status    = st_ff.mode;

endmodule : lpmc_top

`default_nettype wire

// [testbench/lpmc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // core requests
  input wire logic       sleep_req,
  input wire logic       sleep_deep,
  input wire logic       irq_pending,
  input wire logic       wkup_irq_async,
  // mode outputs
  input wire logic       cpu_clk_on,
  input wire logic       sys_clk_on,
  input wire logic       clk_limit,
  input wire logic       reg_lp,
  input wire logic       lvd_en,
  input wire logic [2:0] ram_pwr,
  input wire logic       regfile_pwr,
  input wire logic       io_hold,
  input wire logic       wakeup_reset,
  input wire logic [3:0] mode_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_wait_entry:
    assert property (mode_status == 4'h0 && sleep_req && !sleep_deep
      |=> mode_status == 4'h1) else $error("sleep did not enter wait");
  a_io_frozen:
    assert property (!(mode_status inside {4'h0, 4'h3, 4'ha}) |-> io_hold)
      else $error("pins not held");
  a_wait_clocks:
    assert property (mode_status == 4'h1 |-> !cpu_clk_on && sys_clk_on)
      else $error("wait clocks wrong");
  a_stop_detect:
    assert property (mode_status == 4'h2 |-> lvd_en && !sys_clk_on)
      else $error("stop state wrong");
  a_very_low_power_run_limits:
    assert property (mode_status == 4'h3 |-> reg_lp && !lvd_en && clk_limit)
      else $error("low power run state wrong");
  a_very_low_power_wait_return:
    assert property (mode_status == 4'h4 && irq_pending
      |=> mode_status == 4'h3) else $error("bad return from vlp wait");
  a_lls_ignore:
    assert property (mode_status == 4'h6 && irq_pending && !wkup_irq_async
      && !$past(wkup_irq_async, 1) && !$past(wkup_irq_async, 2)
      && !$past(wkup_irq_async, 3) && !$past(wkup_irq_async, 4)
      |=> mode_status == 4'h6 && ram_pwr == 3'h7) else $error("lls left");
  a_dls1_ram:
    assert property (mode_status == 4'h9 |-> ram_pwr == 3'h0 && regfile_pwr)
      else $error("deep one power wrong");
  a_wrst_pulse:
    assert property ($rose(wakeup_reset) |=> !wakeup_reset
      && mode_status == 4'h0) else $error("wakeup reset pulse wrong");
endmodule : lpmc_props
bind lpmc_top lpmc_props u_props (.core_clk, .rst, .sleep_req, .sleep_deep,
  .irq_pending, .wkup_irq_async, .cpu_clk_on, .sys_clk_on, .clk_limit,
  .reg_lp, .lvd_en,
  .ram_pwr, .regfile_pwr, .io_hold, .wakeup_reset, .mode_status);
`default_nettype wire

// [testbench/lpmc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
  // clock
  input  wire logic core_clk,
  // core and wakeup side
  output logic       sleep_req,
  output logic       sleep_deep,
  output logic       irq_pending,
  output logic [2:0] stop_mode_sel,
  output logic       wkup_irq_async
);
  initial begin
    sleep_req = 1'b0;
    sleep_deep = 1'b0;
    irq_pending = 1'b0;
    stop_mode_sel = 3'h0;
    wkup_irq_async = 1'b0;
  end
  // one sleep instruction; qualifiers scrambled once it is taken
  task sleep(input logic d, input logic [2:0] s);
    @(posedge core_clk);
    #1;
    sleep_req = 1'b1;
    sleep_deep = d;
    stop_mode_sel = s;
    @(posedge core_clk);
    #1;
    sleep_req = 1'b0;
    sleep_deep = ~d;
    stop_mode_sel = ~s;
  endtask : sleep
  task irq;
    @(posedge core_clk);
    #1;
    irq_pending = 1'b1;
    @(posedge core_clk);
    #1;
    irq_pending = 1'b0;
  endtask : irq
  task wake(input logic v);
    @(posedge core_clk);
    #1;
    wkup_irq_async = v;
  endtask : wake
endmodule : lpmc_core_model
`default_nettype wire

// [testbench/test_low_power_mode_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_controller;
  logic       core_clk, rst, sleep_req, sleep_deep, irq_pending;
  logic       vlp_run_req, ram2_keep, wkup_irq_async, cpu_clk_on;
  logic       sys_clk_on, clk_limit, core_tick, bus_tick, reg_lp, lvd_en;
  logic       regfile_pwr, adc_pin_irq_en, lp_periph_en, wkup_unit_en;
  logic       io_hold, wakeup_reset;
  logic [2:0] stop_mode_sel, ram_pwr;
  logic [3:0] mode_status;
  int         miscompares, n_checks;
  lpmc_top dut (.core_clk, .rst, .sleep_req, .sleep_deep, .irq_pending,
    .vlp_run_req, .stop_mode_sel, .ram2_keep, .wkup_irq_async, .cpu_clk_on,
    .sys_clk_on, .clk_limit, .core_tick, .bus_tick, .reg_lp, .lvd_en,
    .ram_pwr, .regfile_pwr, .adc_pin_irq_en, .lp_periph_en, .wkup_unit_en,
    .io_hold, .wakeup_reset, .mode_status);
  lpmc_core_model core (.core_clk, .sleep_req, .sleep_deep, .irq_pending,
    .stop_mode_sel, .wkup_irq_async);
  task conclude;
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // c = {cpu, sys, limit, reg lp, lvd, ram banks}
  task see(input logic [3:0] m, input logic [7:0] c);
    logic h;
    h = !(m == 4'h0 || m == 4'h3);
    chk(16'({mode_status, cpu_clk_on, sys_clk_on, clk_limit, reg_lp,
      lvd_en, ram_pwr, io_hold}), 16'({m, c, h}));
  endtask : see
  task await(input logic [3:0] m);
    int i;
    for (i = 0; i < 20 && mode_status !== m; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (mode_status !== m) begin
      miscompares++;
      conclude();
    end
  endtask : await
  task step;
    @(posedge core_clk);
    #1;
  endtask : step
  task s_wait;
    core.sleep(1'b0, 3'h0);
    see(4'h1, 8'h4f);
    chk(16'({core_tick, bus_tick}), 16'h0003);
    core.irq();
    see(4'h0, 8'hcf);
  endtask : s_wait
  task s_stop;
    core.sleep(1'b1, 3'h0);
    see(4'h2, 8'h0f);
    core.irq();
    see(4'h0, 8'hcf);
  endtask : s_stop
  task s_vlp;
    int nb, nc, i;
    vlp_run_req = 1'b1;
    step();
    see(4'h3, 8'hf7);
    nb = 0;
    nc = 0;
    // any 250-cycle span holds exactly two bus ticks
    for (i = 0; i < 252; i++) begin
      step();
      if (i < 250 && bus_tick === 1'b1) nb++;
      if (core_tick === 1'b1) nc++;
    end
    chk(16'(nb), 16'h0002);
    chk(16'(nc), 16'h0004);
    core.sleep(1'b0, 3'h0);
    see(4'h4, 8'h77);
    core.irq();
    see(4'h3, 8'hf7);
    core.sleep(1'b1, 3'h0);
    see(4'h5, 8'h17);
    chk(16'(adc_pin_irq_en), 16'h0001);
    core.irq();
    see(4'h3, 8'hf7);
    vlp_run_req = 1'b0;
    step();
    see(4'h0, 8'hcf);
  endtask : s_vlp
  task s_lls;
    core.sleep(1'b1, 3'h2);
    see(4'h6, 8'h17);
    chk(16'(wkup_unit_en), 16'h0001);
    chk(16'({adc_pin_irq_en, lp_periph_en}), 16'h0001);
    core.irq();
    see(4'h6, 8'h17);
    core.wake(1'b1);
    await(4'h0);
    see(4'h0, 8'hcf);
    core.wake(1'b0);
    repeat (6) step();
  endtask : s_lls
  task s_deep(input logic [2:0] s, input logic [3:0] m, input logic [7:0] c);
    core.sleep(1'b1, s);
    see(m, c);
    chk(16'(regfile_pwr), 16'h0001);
    core.irq();
    see(m, c);
    core.wake(1'b1);
    await(4'ha);
    chk(16'(wakeup_reset), 16'h0001);
    core.wake(1'b0);
    chk(16'({mode_status, wakeup_reset}), 16'h0000);
    repeat (6) step();
  endtask : s_deep
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    vlp_run_req = 1'b0;
    ram2_keep = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    s_wait();
    s_stop();
    s_vlp();
    s_lls();
    s_deep(3'h3, 4'h7, 8'h17);
    s_deep(3'h4, 4'h8, 8'h13);
    s_deep(3'h5, 4'h9, 8'h10);
    ram2_keep = 1'b0;
    s_deep(3'h4, 4'h8, 8'h11);
    conclude();
  end
endmodule : test_low_power_mode_controller
`default_nettype wire
